/* hdl/tmr_pkg.sv */
// Purpose: types shared by the timer/pwm unit
// Assumes: constants come from tmr_regs.svh
// Notes: none
`include "tmr_regs.svh"

package tmr_pkg;

  typedef enum logic [1:0] {
    COH_IDLE,
    COH_WAIT_LO,
    COH_WAIT_HI
  } tmr_coh_t;

  typedef struct packed {
    logic flag;
    logic ie;
    logic [1:0] mode;
    logic [1:0] edge_sel;
    logic [7:0] buf_hi;
    logic [7:0] buf_lo;
    logic got_hi;
    logic got_lo;
    logic pend;
    logic [15:0] val;
    logic out;
  } tmr_chan_t;

  typedef struct packed {
    logic center_aligned_select;
    logic [1:0] clks;
    logic [2:0] ps;
    logic [6:0] pre;
    logic [15:0] cnt;
    logic [15:0] modv;
    logic [15:0] hold;
    tmr_coh_t coh;
    logic [2:0] ext_sync;
    logic [2:0] fix_sync;
    tmr_chan_t [`TMR_NUM_CH-1:0] ch;
    logic [7:0] rdata;
  } tmr_state_t;

endpackage

/* hdl/tmr_regs.svh */
// Purpose: register map, field positions, reset values of the timer/pwm unit
// Assumes: 8-bit register port, offsets are byte indices on that port
// Notes: channel n registers sit at TMR_CH_BASE + n * TMR_CH_STRIDE
`ifndef TMR_REGS_SVH
`define TMR_REGS_SVH

`define TMR_NUM_CH 2
`define TMR_ADDR_W 5

`define TMR_OFF_SC 5'h00
`define TMR_OFF_CNT_HI 5'h01
`define TMR_OFF_CNT_LO 5'h02
`define TMR_OFF_MOD_HI 5'h03
`define TMR_OFF_MOD_LO 5'h04
`define TMR_CH_BASE 5'h05
`define TMR_CH_STRIDE 5'h03
`define TMR_CH_OFF_SC 5'h00
`define TMR_CH_OFF_VH 5'h01
`define TMR_CH_OFF_VL 5'h02

// timer status/control fields
`define TMR_SC_CENTER_ALIGNED_SELECT 5
`define TMR_SC_CLKS_HI 4
`define TMR_SC_CLKS_LO 3
`define TMR_SC_PS_HI 2
`define TMR_SC_PS_LO 0

// channel status/control fields
`define TMR_CSC_FLAG 7
`define TMR_CSC_IE 6
`define TMR_CSC_MODE_HI 5
`define TMR_CSC_MODE_LO 4
`define TMR_CSC_EDGE_HI 3
`define TMR_CSC_EDGE_LO 2

// clock source codes
`define TMR_CLKS_OFF 2'h0
`define TMR_CLKS_BUS 2'h1
`define TMR_CLKS_FIXED 2'h2
`define TMR_CLKS_EXT 2'h3

// channel mode codes
`define TMR_MODE_SW 2'h0
`define TMR_MODE_OC 2'h1
`define TMR_MODE_EPWM 2'h2

// output compare edge actions
`define TMR_EDGE_NONE 2'h0
`define TMR_EDGE_TOGGLE 2'h1
`define TMR_EDGE_CLEAR 2'h2
`define TMR_EDGE_SET 2'h3

`define TMR_RST_SC 6'h00
`define TMR_RST_CNT 16'h0000
`define TMR_RST_MOD 16'h0000
`define TMR_RST_CVAL 16'h0000
`define TMR_RST_RDATA 8'h00

`endif

/* hdl/tmr_unit.sv */
// Purpose: 16-bit timer with coherent byte access, output compare and edge pwm
// Assumes: single clock; ext_clk and fixed_clk arrive from outside and are synchronised
// Notes: register port is 8 bits wide; read data appear the cycle after rd_en
`include "tmr_regs.svh"

module tmr_unit (
  input wire logic clk,
  input wire logic srst,
  input wire logic [`TMR_ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  input wire logic ext_clk,
  input wire logic fixed_clk,
  output logic [`TMR_NUM_CH-1:0] ch_out,
  output logic [`TMR_NUM_CH-1:0] ch_oe,
  output logic [`TMR_NUM_CH-1:0] ch_irq
);

  tmr_pkg::tmr_state_t s_ff;
  tmr_pkg::tmr_state_t nxt_s;

  logic src_pulse;
  logic tick;
  logic [6:0] pre_mask;
  logic [15:0] cnt_step;
  logic wrap;
  logic [`TMR_ADDR_W-1:0] ch_addr;
  logic [15:0] new_val;
  logic match;

  always_comb begin
    nxt_s = s_ff;
    src_pulse = 1'b0;
    tick = 1'b0;
    pre_mask = 7'h00;
    cnt_step = 16'h0000;
    wrap = 1'b0;
    ch_addr = '0;
    new_val = 16'h0000;
    match = 1'b0;

    // source synchronisers; first stage feeds only the second
    nxt_s.ext_sync = {s_ff.ext_sync[1:0], ext_clk};
    nxt_s.fix_sync = {s_ff.fix_sync[1:0], fixed_clk};

    unique case (s_ff.clks)
      `TMR_CLKS_OFF: src_pulse = 1'b0;
      `TMR_CLKS_BUS: src_pulse = 1'b1;
      `TMR_CLKS_FIXED: src_pulse = s_ff.fix_sync[1] & ~s_ff.fix_sync[2];
      `TMR_CLKS_EXT: src_pulse = s_ff.ext_sync[1] & ~s_ff.ext_sync[2];
    endcase

    // prescaler: ps takes effect the cycle after it is written
    pre_mask = 7'((8'h01 << s_ff.ps) - 8'h01);
    if (src_pulse) begin
      nxt_s.pre = s_ff.pre + 7'h01;
      tick = ((s_ff.pre & pre_mask) == pre_mask);
    end

    // modulus 0 or all ones both wrap at the top of the range
    if (s_ff.modv == 16'h0000) begin
      wrap = (s_ff.cnt == 16'hffff);
    end else begin
      wrap = (s_ff.cnt == s_ff.modv);
    end
    cnt_step = wrap ? 16'h0000 : s_ff.cnt + 16'h0001;
    if (tick) begin
      nxt_s.cnt = cnt_step;
    end

    // per-channel compare, pwm and buffered value load
    for (int i = 0; i < `TMR_NUM_CH; i++) begin
      match = tick && (cnt_step == s_ff.ch[i].val);
      if (s_ff.ch[i].pend && tick) begin
        if (s_ff.ch[i].mode == `TMR_MODE_EPWM && !s_ff.center_aligned_select) begin
          if (cnt_step == s_ff.modv) begin
            nxt_s.ch[i].val = {s_ff.ch[i].buf_hi, s_ff.ch[i].buf_lo};
            nxt_s.ch[i].pend = 1'b0;
          end
        end else begin
          nxt_s.ch[i].val = {s_ff.ch[i].buf_hi, s_ff.ch[i].buf_lo};
          nxt_s.ch[i].pend = 1'b0;
        end
      end
      if (match) begin
        nxt_s.ch[i].flag = 1'b1;
      end
      if (s_ff.ch[i].mode == `TMR_MODE_EPWM && !s_ff.center_aligned_select) begin
        // match beats overflow so a zero compare never shows the active level
        if (match) begin
          nxt_s.ch[i].out = s_ff.ch[i].edge_sel[0];
        end else if (tick && wrap) begin
          // a compare above modulus never matches: full duty
          nxt_s.ch[i].out = ~s_ff.ch[i].edge_sel[0];
        end
      end else if (s_ff.ch[i].mode == `TMR_MODE_OC && match) begin
        unique case (s_ff.ch[i].edge_sel)
          `TMR_EDGE_NONE: nxt_s.ch[i].out = s_ff.ch[i].out;
          `TMR_EDGE_TOGGLE: nxt_s.ch[i].out = ~s_ff.ch[i].out;
          `TMR_EDGE_CLEAR: nxt_s.ch[i].out = 1'b0;
          `TMR_EDGE_SET: nxt_s.ch[i].out = 1'b1;
        endcase
      end
    end

    // register writes
    if (wr_en) begin
      if (addr == `TMR_OFF_SC) begin
        nxt_s.center_aligned_select = wdata[`TMR_SC_CENTER_ALIGNED_SELECT];
        nxt_s.clks = wdata[`TMR_SC_CLKS_HI:`TMR_SC_CLKS_LO];
        nxt_s.ps = wdata[`TMR_SC_PS_HI:`TMR_SC_PS_LO];
        nxt_s.coh = tmr_pkg::COH_IDLE;
      end else if (addr == `TMR_OFF_CNT_HI || addr == `TMR_OFF_CNT_LO) begin
        nxt_s.cnt = `TMR_RST_CNT;
        nxt_s.pre = 7'h00;
      end else if (addr == `TMR_OFF_MOD_HI) begin
        nxt_s.modv[15:8] = wdata;
      end else if (addr == `TMR_OFF_MOD_LO) begin
        nxt_s.modv[7:0] = wdata;
      end
      for (int i = 0; i < `TMR_NUM_CH; i++) begin
        ch_addr = `TMR_ADDR_W'(`TMR_CH_BASE + `TMR_CH_STRIDE * i);
        if (addr == ch_addr + `TMR_CH_OFF_SC) begin
          nxt_s.ch[i].ie = wdata[`TMR_CSC_IE];
          nxt_s.ch[i].mode = wdata[`TMR_CSC_MODE_HI:`TMR_CSC_MODE_LO];
          nxt_s.ch[i].edge_sel = wdata[`TMR_CSC_EDGE_HI:`TMR_CSC_EDGE_LO];
          nxt_s.ch[i].got_hi = 1'b0;
          nxt_s.ch[i].got_lo = 1'b0;
          // writing 0 clears the flag, a match in the same cycle wins
          if (!wdata[`TMR_CSC_FLAG] && !(tick && cnt_step == s_ff.ch[i].val)) begin
            nxt_s.ch[i].flag = 1'b0;
          end
        end else if (addr == ch_addr + `TMR_CH_OFF_VH ||
                     addr == ch_addr + `TMR_CH_OFF_VL) begin
          if (addr == ch_addr + `TMR_CH_OFF_VH) begin
            nxt_s.ch[i].buf_hi = wdata;
            nxt_s.ch[i].got_hi = 1'b1;
          end else begin
            nxt_s.ch[i].buf_lo = wdata;
            nxt_s.ch[i].got_lo = 1'b1;
          end
          if (nxt_s.ch[i].got_hi && nxt_s.ch[i].got_lo) begin
            nxt_s.ch[i].got_hi = 1'b0;
            nxt_s.ch[i].got_lo = 1'b0;
            new_val = {nxt_s.ch[i].buf_hi, nxt_s.ch[i].buf_lo};
            if (s_ff.clks == `TMR_CLKS_OFF) begin
              nxt_s.ch[i].val = new_val;
              nxt_s.ch[i].pend = 1'b0;
            end else begin
              nxt_s.ch[i].pend = 1'b1;
            end
          end
        end
      end
    end

    // register reads, answered one cycle later
    nxt_s.rdata = `TMR_RST_RDATA;
    if (rd_en) begin
      if (addr == `TMR_OFF_SC) begin
        nxt_s.rdata = {2'h0, s_ff.center_aligned_select, s_ff.clks, s_ff.ps};
      end else if (addr == `TMR_OFF_CNT_HI) begin
        // first read of a pair freezes both bytes until the other is read or SC is written
        if (s_ff.coh == tmr_pkg::COH_IDLE) begin
          nxt_s.hold = s_ff.cnt;
          nxt_s.rdata = s_ff.cnt[15:8];
          nxt_s.coh = tmr_pkg::COH_WAIT_LO;
        end else begin
          nxt_s.rdata = s_ff.hold[15:8];
          if (s_ff.coh == tmr_pkg::COH_WAIT_HI) begin
            nxt_s.coh = tmr_pkg::COH_IDLE;
          end
        end
      end else if (addr == `TMR_OFF_CNT_LO) begin
        if (s_ff.coh == tmr_pkg::COH_IDLE) begin
          nxt_s.hold = s_ff.cnt;
          nxt_s.rdata = s_ff.cnt[7:0];
          nxt_s.coh = tmr_pkg::COH_WAIT_HI;
        end else begin
          nxt_s.rdata = s_ff.hold[7:0];
          if (s_ff.coh == tmr_pkg::COH_WAIT_LO) begin
            nxt_s.coh = tmr_pkg::COH_IDLE;
          end
        end
      end else if (addr == `TMR_OFF_MOD_HI) begin
        nxt_s.rdata = s_ff.modv[15:8];
      end else if (addr == `TMR_OFF_MOD_LO) begin
        nxt_s.rdata = s_ff.modv[7:0];
      end
      for (int i = 0; i < `TMR_NUM_CH; i++) begin
        ch_addr = `TMR_ADDR_W'(`TMR_CH_BASE + `TMR_CH_STRIDE * i);
        if (addr == ch_addr + `TMR_CH_OFF_SC) begin
          nxt_s.rdata = {s_ff.ch[i].flag, s_ff.ch[i].ie, s_ff.ch[i].mode,
                         s_ff.ch[i].edge_sel, 2'h0};
        end else if (addr == ch_addr + `TMR_CH_OFF_VH) begin
          nxt_s.rdata = s_ff.ch[i].buf_hi;
        end else if (addr == ch_addr + `TMR_CH_OFF_VL) begin
          nxt_s.rdata = s_ff.ch[i].buf_lo;
        end
      end
    end

    if (srst) begin
      nxt_s = '0;
      nxt_s.center_aligned_select = 1'(`TMR_RST_SC >> `TMR_SC_CENTER_ALIGNED_SELECT);
      nxt_s.cnt = `TMR_RST_CNT;
      nxt_s.modv = `TMR_RST_MOD;
      nxt_s.coh = tmr_pkg::COH_IDLE;
      for (int i = 0; i < `TMR_NUM_CH; i++) begin
        nxt_s.ch[i].val = `TMR_RST_CVAL;
      end
    end
  end

  always_ff @(posedge clk) begin
    s_ff <= nxt_s;
  end

  assign rdata = s_ff.rdata;

  // pin is driven only when a mode and an edge/level action are chosen and the clock runs
  always_comb begin
    for (int i = 0; i < `TMR_NUM_CH; i++) begin
      ch_out[i] = s_ff.ch[i].out;
      ch_oe[i] = (s_ff.ch[i].mode != `TMR_MODE_SW) &&
                 (s_ff.ch[i].edge_sel != `TMR_EDGE_NONE) &&
                 (s_ff.clks != `TMR_CLKS_OFF);
      ch_irq[i] = s_ff.ch[i].flag & s_ff.ch[i].ie;
    end
  end

endmodule

/* verif/tmr_unit_bench.sv */
// Purpose: self-checking bench for the timer/pwm unit
// Assumes: register map of tmr_regs.svh
// Notes: reads are scored by a monitor against a queue of expected bytes
`include "tmr_regs.svh"
module tmr_unit_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [4:0] addr = 5'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic ext_clk = 1'b0;
  logic fixed_clk = 1'b0;
  logic [7:0] rdata;
  logic [1:0] ch_out;
  logic [1:0] ch_oe;
  logic [1:0] ch_irq;
  logic rd_q = 1'b0;
  logic [7:0] exp_q[$];
  int bad_count = 0;
  int compares = 0;
  integer seed = 32'hb76cdf2d;
  tmr_unit uut (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .ext_clk(ext_clk), .fixed_clk(fixed_clk),
    .ch_out(ch_out), .ch_oe(ch_oe), .ch_irq(ch_irq));
  always #2 clk = ~clk;
  always begin
    repeat (3) @(posedge clk);
    fixed_clk <= ~fixed_clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  always @(posedge clk) begin
    if (rd_q) chk({8'h00, rdata}, {8'h00, exp_q.pop_front()});
    rd_q <= rd_en;
  end
  task automatic conclude;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // every task is entered just after a rising edge
  task automatic bus(input logic w, input logic r, input logic [4:0] a, input logic [7:0] d);
    wr_en <= w;
    rd_en <= r;
    addr <= a;
    wdata <= d;
    @(posedge clk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, 1'b1, a, 8'h00);
  endtask
  task automatic idle(input int n);
    bus(1'b0, 1'b0, addr, wdata);
    repeat (n - 1) @(posedge clk);
  endtask
  task automatic pulses(input int n);
    idle(1);
    repeat (n) begin
      ext_clk <= 1'b1;
      repeat (4) @(posedge clk);
      ext_clk <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask
  task automatic setv(input logic [7:0] v);
    wr(`TMR_CH_BASE + 5'h01, 8'h00);
    wr(`TMR_CH_BASE + 5'h02, v);
  endtask
  // window is a multiple of the 4-tick period, so phase does not matter
  task automatic duty(input int exp);
    int hi;
    hi = 0;
    idle(20);
    repeat (40) begin
      @(posedge clk);
      if (ch_out[0] === 1'b1) hi++;
    end
    chk(16'(hi), 16'(exp));
  endtask
  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    wr(`TMR_OFF_CNT_HI, 8'($random(seed)));
    wr(`TMR_OFF_SC, 8'h18);
    pulses(5);
    rd(`TMR_OFF_CNT_LO, 8'h05);
    pulses(3);
    rd(`TMR_OFF_CNT_LO, 8'h05);
    rd(`TMR_OFF_CNT_HI, 8'h00);
    rd(`TMR_OFF_CNT_LO, 8'h08);
    rd(`TMR_OFF_CNT_LO, 8'h08);
    rd(`TMR_OFF_CNT_LO, 8'h08);
    pulses(2);
    wr(`TMR_OFF_SC, 8'h18);
    rd(`TMR_OFF_CNT_LO, 8'h0a);
    rd(`TMR_OFF_CNT_HI, 8'h00);
    wr(`TMR_OFF_CNT_LO, 8'($random(seed)));
    rd(`TMR_OFF_CNT_LO, 8'h00);
    rd(`TMR_OFF_CNT_HI, 8'h00);
    rd(5'h1f, 8'h00);
    wr(`TMR_OFF_SC, 8'h19);
    pulses(4);
    rd(`TMR_OFF_CNT_LO, 8'h02);
    wr(`TMR_OFF_SC, 8'h00);
    wr(`TMR_OFF_MOD_LO, 8'h03);
    wr(`TMR_CH_BASE, 8'h28);
    setv(8'h02);
    wr(`TMR_CH_BASE + `TMR_CH_STRIDE, 8'h54);
    wr(`TMR_CH_BASE + `TMR_CH_STRIDE + 5'h02, 8'h02);
    wr(`TMR_CH_BASE + `TMR_CH_STRIDE + 5'h01, 8'h00);
    wr(`TMR_OFF_SC, 8'h08);
    rd(`TMR_OFF_SC, 8'h08);
    duty(20);
    rd(`TMR_CH_BASE, 8'ha8);
    chk(16'(ch_irq[1]), 16'h0001);
    wr(`TMR_CH_BASE + `TMR_CH_STRIDE, 8'h14);
    idle(2);
    chk(16'(ch_irq[1]), 16'h0000);
    setv(8'h01);
    duty(10);
    wr(`TMR_CH_BASE, 8'h2c);
    duty(30);
    wr(`TMR_CH_BASE, 8'h28);
    setv(8'h00);
    duty(0);
    setv(8'h05);
    duty(40);
    wr(`TMR_OFF_SC, 8'h00);
    wr(`TMR_CH_BASE + 5'h01, 8'h00);
    wr(`TMR_CH_BASE, 8'h28);
    wr(`TMR_CH_BASE + 5'h02, 8'h01);
    wr(`TMR_OFF_SC, 8'h08);
    duty(40);
    wr(`TMR_CH_BASE + 5'h01, 8'h00);
    duty(10);
    setv(8'h05);
    duty(40);
    // centre-aligned set: a zero compare must not pull the held level low
    wr(`TMR_OFF_SC, 8'h20);
    setv(8'h00);
    wr(`TMR_OFF_SC, 8'h28);
    duty(40);
    for (int c = 0; c < 4; c++) begin
      wr(`TMR_OFF_SC, 8'(c << 3));
      rd(`TMR_OFF_SC, 8'(c << 3));
      idle(8);
    end
    idle(4);
    conclude();
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    conclude();
  end
endmodule

/* verif/tmr_unit_properties.sv */
// Purpose: port-level properties of the timer/pwm unit
// Assumes: control registers are shadowed from writes seen on the port
// Notes: the event flag is not shadowed since it moves by itself
`include "tmr_regs.svh"
module tmr_unit_chk (
  input wire logic clk,
  input wire logic srst,
  input wire logic [`TMR_ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] rdata,
  input wire logic ext_clk,
  input wire logic fixed_clk,
  input wire logic [`TMR_NUM_CH-1:0] ch_out,
  input wire logic [`TMR_NUM_CH-1:0] ch_oe,
  input wire logic [`TMR_NUM_CH-1:0] ch_irq
);
  typedef struct packed {
    logic [5:0] sc;
    logic [1:0][4:0] csc;
  } tmr_chk_t;
  tmr_chk_t sh_ff;
  tmr_chk_t nxt_sh;
  logic [1:0] oe_exp;
  always_comb begin
    nxt_sh = sh_ff;
    if (wr_en && addr == `TMR_OFF_SC) nxt_sh.sc = wdata[5:0];
    if (wr_en && addr == `TMR_CH_BASE) nxt_sh.csc[0] = wdata[6:2];
    if (wr_en && addr == `TMR_CH_BASE + `TMR_CH_STRIDE) nxt_sh.csc[1] = wdata[6:2];
  end
  always_ff @(posedge clk) begin
    if (srst) sh_ff <= '0;
    else sh_ff <= nxt_sh;
  end
  // pin is driven only with a mode, an edge action and a running source
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      oe_exp[i] = sh_ff.csc[i][3:2] != 2'h0 && sh_ff.csc[i][1:0] != 2'h0 && sh_ff.sc[4:3] != 2'h0;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  property p_rdata_idle;
    !rd_en |=> rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("idle read data");
  property p_unmapped;
    rd_en && addr > 5'h0a |=> rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_sc_readback;
    rd_en && addr == `TMR_OFF_SC |=> rdata == {2'h0, $past(sh_ff.sc)};
  endproperty
  a_sc_readback: assert property (p_sc_readback) else $error("status readback");
  property p_csc_readback;
    rd_en && addr == `TMR_CH_BASE |=> rdata[6:2] == $past(sh_ff.csc[0]);
  endproperty
  a_csc_readback: assert property (p_csc_readback) else $error("channel readback");
  property p_oe;
    ch_oe == oe_exp;
  endproperty
  a_oe: assert property (p_oe) else $error("output enable");
  property p_stopped_hold;
    sh_ff.sc[4:3] == 2'h0 && !wr_en |=> $stable(ch_out);
  endproperty
  a_stopped_hold: assert property (p_stopped_hold) else $error("output moved, stopped");
  property p_irq_ie;
    (ch_irq & ~{sh_ff.csc[1][4], sh_ff.csc[0][4]}) == 2'h0;
  endproperty
  a_irq_ie: assert property (p_irq_ie) else $error("irq without enable");
  sequence s_lo_rd;
    rd_en && addr == `TMR_OFF_CNT_LO;
  endsequence
  property p_cnt_reread;
    s_lo_rd ##1 s_lo_rd ##1 s_lo_rd |=> rdata == $past(rdata);
  endproperty
  a_cnt_reread: assert property (p_cnt_reread) else $error("held count moved");
endmodule

bind tmr_unit tmr_unit_chk u_chk (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata),
  .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .ext_clk(ext_clk), .fixed_clk(fixed_clk),
  .ch_out(ch_out), .ch_oe(ch_oe), .ch_irq(ch_irq));
